// ---- hdl/dpa_pkg.sv ----
package dpa_pkg;
    // memory geometry of one master device
    localparam int ADDR_W = 11;
    localparam int DATA_W = 9;
    // settle time between address/select valid and write strobe
    localparam int SETTLE_NS = 30;
    localparam int CLK_NS = 10;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
    // strobe width; write data is released with the strobe, with no hold after it
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    // host access sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        DPA_IDLE = 3'b000,
        DPA_SETUP = 3'b001,
        DPA_STROBE = 3'b011,
        DPA_DONE = 3'b010,
        DPA_WAIT = 3'b110
    } dpa_state_e;
endpackage

// ---- hdl/dpa_host_port.sv ----
`timescale 1ns/1ps
module dpa_host_port (
    input wire logic sys_clk,
    input wire logic rst,
    // user request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [dpa_pkg::ADDR_W-1:0] req_addr,
    input wire logic [dpa_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [dpa_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_error,
    // memory port pins
    output logic mem_sel_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [dpa_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [dpa_pkg::DATA_W-1:0] mem_data_in,
    output logic [dpa_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_n,
    input wire logic mem_busy_n,
    // other port busy, for the illegal access event
    input wire logic peer_busy_n,
    output logic clash_event
);
    import dpa_pkg::*;

    // idle: the only state in which a request is taken
    function automatic logic idle_state(input dpa_state_e st);
        return st == DPA_IDLE;
    endfunction

    // select is held from setup through strobe, wait included
    function automatic logic port_selected(input dpa_state_e st);
        return (st != DPA_IDLE) && (st != DPA_DONE);
    endfunction

    // strobe phase, shared by both strobes and the capture point
    function automatic logic strobing(input dpa_state_e st);
        return st == DPA_STROBE;
    endfunction

    // and of active-low flags, the same gate that forms a stacked array's flag
    function automatic logic flags_free(input logic a, input logic b);
        return a & b;
    endfunction

    // sequencer state
    dpa_state_e state, next_state;
    logic [3:0] cnt, next_cnt;
    // request fields, captured at take
    logic wr, next_wr;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wdata, next_wdata;
    // response to the user
    logic [DATA_W-1:0] rdata, next_rdata;
    logic rvalid, next_rvalid;
    logic rerr, next_rerr;
    // illegal simultaneous access event
    logic clash, next_clash;
    // decoded events shared by several groups
    logic take, strobe_end, flag_seen;

    // events: request taken, last strobe cycle, flag on this port
    always_comb begin
        take = idle_state(state) && req_valid;
        strobe_end = strobing(state) && (cnt == CNT_ZERO);
        flag_seen = ~mem_busy_n;
    end

    // sequencer: select and address, settle, strobe, then release
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            DPA_IDLE: begin
                if (take) begin
                    next_cnt = SETTLE_CNT;
                    next_state = DPA_SETUP;
                end
            end
            DPA_SETUP: begin
                // address and select settle so the flag is valid before any strobe
                if (cnt != CNT_ZERO) begin
                    next_cnt = cnt - 4'h1;
                end else if (flag_seen) begin
                    // the one flag decides for the whole word; tied low it blocks for good
                    next_state = DPA_WAIT;
                end else begin
                    // flag high: the strobe goes ahead unhindered
                    next_cnt = STROBE_CNT;
                    next_state = DPA_STROBE;
                end
            end
            DPA_WAIT: begin
                // hold off until the other port finishes, then settle again
                if (!flag_seen) begin
                    next_cnt = SETTLE_CNT;
                    next_state = DPA_SETUP;
                end
            end
            DPA_STROBE: begin
                // busy arriving now does not cut the strobe; the device gates it
                if (cnt != CNT_ZERO) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    next_state = DPA_DONE;
                end
            end
            DPA_DONE: begin
                next_state = DPA_IDLE;
            end
            default: begin
                next_cnt = CNT_ZERO;
                next_state = DPA_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= DPA_IDLE;
            cnt <= CNT_ZERO;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // request capture: fields stand from take until the next take
    always_comb begin
        next_wr = wr;
        next_addr = addr;
        next_wdata = wdata;
        if (take) begin
            next_wr = req_write;
            next_addr = req_addr;
            next_wdata = req_wdata;
        end
    end

    // capture registers; address stays put while selected
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr <= 1'b0;
            addr <= '0;
            wdata <= '0;
        end else begin
            wr <= next_wr;
            addr <= next_addr;
            wdata <= next_wdata;
        end
    end

    // response: data and flag are taken at the last strobe cycle
    always_comb begin
        next_rdata = rdata;
        next_rerr = rerr;
        next_rvalid = (state == DPA_DONE);
        if (strobe_end) begin
            next_rdata = mem_data_in;
            // flag at strobe end: read data unreliable, or the write was inhibited
            next_rerr = flag_seen;
        end
    end

    // response registers; the valid pulse follows the release cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= '0;
            rvalid <= 1'b0;
            rerr <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            rerr <= next_rerr;
        end
    end

    // either port's flag marks an illegal simultaneous access
    always_comb begin
        next_clash = ~flags_free(mem_busy_n, peer_busy_n);
    end

    // clash register, one cycle behind the flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clash <= 1'b0;
        end else begin
            clash <= next_clash;
        end
    end

    // pin and user outputs; gray steps keep the strobe decode free of glitches
    always_comb begin
        req_ready = idle_state(state);
        rsp_valid = rvalid;
        rsp_rdata = rdata;
        rsp_error = rerr;
        clash_event = clash;
        mem_addr = addr;
        mem_data_out = wdata;
        mem_sel_n = ~port_selected(state);
        mem_we_n = ~(wr && strobing(state));
        mem_oe_n = ~(!wr && strobing(state));
        mem_data_oe_n = ~(wr && port_selected(state));
    end
endmodule // dpa_host_port

// ---- verif/dpa_host_port_assertions.sv ----
`timescale 1ns/1ps
module dpa_host_port_assertions (
    input wire logic sys_clk, rst, mem_sel_n, mem_we_n, mem_oe_n, mem_data_oe_n,
    input wire logic mem_busy_n, peer_busy_n, clash_event,
    input wire logic [dpa_pkg::ADDR_W-1:0] mem_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_sel; !mem_we_n || !mem_oe_n |-> !mem_sel_n; endproperty
    a_sel: assert property (p_sel) else $error("strobe unselected");
    property p_setl; $fell(mem_we_n) |-> $past(mem_sel_n, 4) == 1'b0; endproperty
    a_setl: assert property (p_setl) else $error("short setup");
    property p_hold; $fell(mem_we_n) || $fell(mem_oe_n) |-> $past(mem_busy_n); endproperty
    a_hold: assert property (p_hold) else $error("strobe while flagged");
    property p_wid; $fell(mem_we_n) |-> !mem_we_n [*5] ##1 mem_we_n; endproperty
    a_wid: assert property (p_wid) else $error("strobe width");
    property p_addr; !mem_sel_n ##1 !mem_sel_n |-> $stable(mem_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_drv; !mem_we_n |-> !mem_data_oe_n; endproperty
    a_drv: assert property (p_drv) else $error("data undriven");
    property p_clash; !mem_busy_n |=> clash_event; endproperty
    a_clash: assert property (p_clash) else $error("clash missed");
    property p_calm; mem_busy_n && peer_busy_n |=> !clash_event; endproperty
    a_calm: assert property (p_calm) else $error("false clash");
endmodule // dpa_host_port_assertions
bind dpa_host_port dpa_host_port_assertions chk (.*);

// ---- verif/dpa_mem_model.sv ----
`timescale 1ns/1ps
module dpa_mem_model (
    input wire logic clk, sel_n, we_n, oe_n, peer_sel_n,
    input wire logic [dpa_pkg::ADDR_W-1:0] addr, peer_addr,
    input wire logic [dpa_pkg::DATA_W-1:0] wdata,
    output logic [dpa_pkg::DATA_W-1:0] rdata,
    output logic busy_n
);
    logic [dpa_pkg::DATA_W-1:0] mem [2**dpa_pkg::ADDR_W];
    logic [dpa_pkg::DATA_W-1:0] sav;
    // peer port holds the location, so this port loses; push-pull level
    assign busy_n = !(!sel_n && !peer_sel_n && addr == peer_addr);
    // invalid data when flagged or not enabled
    assign rdata = (!oe_n && busy_n) ? mem[addr] : ~mem[addr];
    // flagged strobe restores the old word
    always @(posedge clk) if (!we_n) mem[addr] <= busy_n ? wdata : sav; else sav <= mem[addr];
endmodule // dpa_mem_model

// ---- verif/dual_port_contention_arbiter_tb.sv ----
`timescale 1ns/1ps
module dual_port_contention_arbiter_tb;
    import dpa_pkg::*;
    logic sys_clk = 0, rst = 1, req_valid = 0, req_write = 0, peer_busy_n = 1, peer_sel_n = 1;
    logic req_ready, rsp_valid, rsp_error, mem_sel_n, mem_we_n, mem_oe_n, mem_data_oe_n, mem_busy_n, clash_event;
    logic [ADDR_W-1:0] req_addr = 0, mem_addr, peer_addr = 0;
    logic [DATA_W-1:0] req_wdata = 0, rsp_rdata, mem_data_in, mem_data_out;
    int n_errors = 0, check_count = 0, cyc = 0;
    dpa_host_port uut (.*);
    dpa_mem_model mdl (.clk(sys_clk), .sel_n(mem_sel_n), .we_n(mem_we_n), .oe_n(mem_oe_n), .peer_sel_n(peer_sel_n),
        .addr(mem_addr), .peer_addr(peer_addr), .wdata(mem_data_out), .rdata(mem_data_in), .busy_n(mem_busy_n));
    initial forever #5 sys_clk = ~sys_clk;
    // hang guard
    always @(posedge sys_clk) if (++cyc == 600) begin
        n_errors++;
        summarize();
    end
    task check(input string nm, input logic [DATA_W-1:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        {req_write, req_addr, req_wdata, req_valid} = {w, a, d, 1'b1};
        @(posedge sys_clk) #1 req_valid = 0;
        while (rsp_valid !== 1'b1) @(posedge sys_clk) #1;
    endtask
    task t_plain;
        acc(1, 11'h7ff, 9'h1a5);
        check("werr", rsp_error, 0);
        acc(0, 11'h7ff, 0);
        check("rd", rsp_rdata, 9'h1a5);
    endtask
    task t_busy;
        {peer_addr, peer_sel_n} = {11'h123, 1'b0};
        fork
            acc(1, 11'h123, 9'h0c3);
            begin
                repeat (12) @(posedge sys_clk);
                #1 check("we", mem_we_n, 1);
                check("clash", clash_event, 1);
                check("wsel", mem_sel_n, 0);
                check("wrdy", req_ready, 0);
                peer_sel_n = 1;
            end
        join
        acc(0, 11'h123, 0);
        check("brd", rsp_rdata, 9'h0c3);
    endtask
    task t_err;
        peer_addr = 11'h7ff;
        fork
            acc(1, 11'h7ff, 9'h0ff);
            begin
                repeat (7) @(posedge sys_clk);
                #1 peer_sel_n = 0;
            end
        join
        check("eerr", rsp_error, 1);
        peer_sel_n = 1;
        acc(0, 11'h7ff, 0);
        check("erd", rsp_rdata, 9'h1a5);
    endtask
    task t_clash;
        check("rdy", req_ready, 1);
        peer_busy_n = 0;
        @(posedge sys_clk) #1 check("pclash", clash_event, 1);
        peer_busy_n = 1;
        @(posedge sys_clk) #1 check("pcalm", clash_event, 0);
    endtask
    task t_reset;
        {req_write, req_addr, req_wdata, req_valid} = {1'b1, 11'h055, 9'h12a, 1'b1};
        @(posedge sys_clk) #1 req_valid = 0;
        repeat (6) @(posedge sys_clk);
        #1 rst = 1;
        repeat (2) @(posedge sys_clk);
        #1 check("rsel", mem_sel_n, 1);
        check("rwe", mem_we_n, 1);
        check("rrdy", req_ready, 1);
        check("rval", rsp_valid, 0);
        rst = 0;
        acc(1, 11'h055, 9'h0aa);
        acc(0, 11'h055, 0);
        check("rrd", rsp_rdata, 9'h0aa);
    endtask
    task summarize;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        t_plain();
        t_busy();
        t_err();
        t_clash();
        t_reset();
        summarize();
    end
endmodule // dual_port_contention_arbiter_tb
